// ### chlcd_decoder.sv
// Command decoder of a character display: commands, character writes, status reads.
// Assumes host strobes come from logic on i_sys_clk, one cycle wide each.
`timescale 1ns/1ns
`include "chlcd_regs.svh"
module chlcd_decoder #(
    parameter int unsigned P_LONG_CYC = `CHLCD_LONG_CYC
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // Host access
    input wire logic i_wr_stb,
    input wire logic i_rs_data,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd_stb,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_busy,
    output logic o_wr_drop,
    // Display state
    output logic o_disp_on,
    output logic o_cursor_on,
    output logic o_blink_on,
    output logic o_entry_inc,
    output logic o_entry_shift,
    output logic o_two_line,
    output logic [6:0] o_cursor_addr,
    output logic [6:0] o_disp_offset,
    output logic [5:0] o_cg_addr,
    // Glyph scan
    input wire logic [6:0] i_scan_addr,
    output logic [7:0] o_scan_code,
    output logic o_scan_blank
);
    import chlcd_pkg::*;

    localparam logic [`CHLCD_CNT_W-1:0] LONG_CNT = `CHLCD_CNT_W'(P_LONG_CYC);
    localparam logic [`CHLCD_CNT_W-1:0] SHORT_CNT = `CHLCD_CNT_W'(`CHLCD_SHORT_CYC);

    chlcd_state_e state_q, state_d;
    logic [`CHLCD_CNT_W-1:0] cnt_q, cnt_d;
    logic [6:0] clr_q, clr_d, cursor_d, offset_d;
    logic [5:0] cg_d;
    logic cg_mode_q, cg_mode_d;
    logic busy_d, drop_d, rvalid_d;
    logic disp_d, curs_d, blink_d, inc_d, shift_d, two_d;
    logic [7:0] rdata_d;
    logic mem_we;
    logic [7:0] mem_waddr, mem_wdata, mem_rdata;
    logic [6:0] step;

    // Next state of the whole command engine
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        clr_d = clr_q;
        cursor_d = o_cursor_addr;
        offset_d = o_disp_offset;
        cg_d = o_cg_addr;
        cg_mode_d = cg_mode_q;
        disp_d = o_disp_on;
        curs_d = o_cursor_on;
        blink_d = o_blink_on;
        inc_d = o_entry_inc;
        shift_d = o_entry_shift;
        two_d = o_two_line;
        drop_d = 1'b0;
        mem_we = 1'b0;
        mem_waddr = {1'b0, o_cursor_addr};
        mem_wdata = i_wdata;
        step = o_entry_inc ? 7'h01 : 7'h7F;
        rvalid_d = i_rd_stb;
        rdata_d = o_rdata;
        // Status sampled from the registered busy flag
        if (i_rd_stb) begin
            rdata_d[`CHLCD_BUSY_BIT] = o_busy;
            rdata_d[6:0] = cg_mode_q ? {1'b0, o_cg_addr} : o_cursor_addr;
        end
        case (state_q)
            CHLCD_ST_IDLE: begin
                if (i_wr_stb) begin
                    state_d = CHLCD_ST_BUSY;
                    cnt_d = SHORT_CNT;
                    if (i_rs_data) begin
                        // Store the code unchanged; the glyph is the code itself
                        mem_we = 1'b1;
                        if (cg_mode_q) begin
                            mem_waddr = {`CHLCD_CG_PAGE, o_cg_addr};
                            cg_d = o_cg_addr + step[5:0];
                        end else begin
                            cursor_d = o_cursor_addr + step;
                            if (o_entry_shift) begin
                                offset_d = o_disp_offset + step;
                            end
                        end
                    end else begin
                        case (chlcd_classify(i_wdata))
                            CHLCD_C_CLEAR: begin
                                state_d = CHLCD_ST_CLEAR;
                                cnt_d = LONG_CNT;
                                clr_d = 7'h00;
                                cursor_d = 7'h00;
                                offset_d = 7'h00;
                                inc_d = 1'b1;
                                cg_mode_d = 1'b0;
                            end
                            CHLCD_C_HOME: begin
                                cnt_d = LONG_CNT;
                                cursor_d = 7'h00;
                                offset_d = 7'h00;
                                cg_mode_d = 1'b0;
                            end
                            CHLCD_C_ENTRY: begin
                                inc_d = i_wdata[1];
                                shift_d = i_wdata[0];
                            end
                            CHLCD_C_DISP: begin
                                disp_d = i_wdata[2];
                                curs_d = i_wdata[1];
                                blink_d = i_wdata[0];
                            end
                            CHLCD_C_SHIFT: begin
                                // Moves a pointer only, the cells stay intact
                                // Left moves the window forward, so the text slides left
                                if (i_wdata[3]) begin
                                    offset_d = o_disp_offset + (i_wdata[2] ? 7'h7F : 7'h01);
                                end else begin
                                    cursor_d = o_cursor_addr + (i_wdata[2] ? 7'h01 : 7'h7F);
                                end
                            end
                            CHLCD_C_FUNC: begin
                                two_d = i_wdata[3];
                            end
                            CHLCD_C_CGADDR: begin
                                cg_d = i_wdata[5:0];
                                cg_mode_d = 1'b1;
                            end
                            CHLCD_C_DDADDR: begin
                                cursor_d = i_wdata[6:0];
                                cg_mode_d = 1'b0;
                            end
                            default: begin
                                cnt_d = SHORT_CNT;
                            end
                        endcase
                    end
                end
            end
            CHLCD_ST_CLEAR: begin
                // One cell per cycle; the long busy time covers all 128
                mem_we = 1'b1;
                mem_waddr = {1'b0, clr_q};
                mem_wdata = `CHLCD_CHAR_SPACE;
                clr_d = clr_q + 7'h01;
                cnt_d = cnt_q - `CHLCD_CNT_ONE;
                drop_d = i_wr_stb;
                if (clr_q == `CHLCD_LAST_CELL) begin
                    state_d = CHLCD_ST_BUSY;
                end
            end
            CHLCD_ST_BUSY: begin
                // Writes while busy are dropped, the host is expected to wait
                drop_d = i_wr_stb;
                cnt_d = cnt_q - `CHLCD_CNT_ONE;
                if (cnt_q == `CHLCD_CNT_ONE) begin
                    state_d = CHLCD_ST_IDLE;
                end
            end
            default: begin
                state_d = CHLCD_ST_IDLE;
            end
        endcase
        busy_d = (state_d != CHLCD_ST_IDLE);
    end

    // Registers of the command engine
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= CHLCD_ST_IDLE;
            cnt_q <= '0;
            clr_q <= 7'h00;
            cg_mode_q <= 1'b0;
            o_busy <= 1'b0;
            o_wr_drop <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 8'h00;
            o_disp_on <= `CHLCD_RST_DISP_ON;
            o_cursor_on <= `CHLCD_RST_CURSOR_ON;
            o_blink_on <= `CHLCD_RST_BLINK_ON;
            o_entry_inc <= `CHLCD_RST_ENTRY_INC;
            o_entry_shift <= `CHLCD_RST_ENTRY_SHIFT;
            o_two_line <= `CHLCD_RST_TWO_LINE;
            o_cursor_addr <= 7'h00;
            o_disp_offset <= 7'h00;
            o_cg_addr <= 6'h00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            clr_q <= clr_d;
            cg_mode_q <= cg_mode_d;
            o_busy <= busy_d;
            o_wr_drop <= drop_d;
            o_rvalid <= rvalid_d;
            o_rdata <= rdata_d;
            o_disp_on <= disp_d;
            o_cursor_on <= curs_d;
            o_blink_on <= blink_d;
            o_entry_inc <= inc_d;
            o_entry_shift <= shift_d;
            o_two_line <= two_d;
            o_cursor_addr <= cursor_d;
            o_disp_offset <= offset_d;
            o_cg_addr <= cg_d;
        end
    end

    chlcd_mem u_mem (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr({1'b0, i_scan_addr + o_disp_offset}),
        .o_rdata(mem_rdata)
    );

    // Scan output: a space or a dark display both read as blank
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_scan_code <= 8'h00;
            o_scan_blank <= 1'b1;
        end else begin
            o_scan_code <= mem_rdata;
            o_scan_blank <= (mem_rdata == `CHLCD_CHAR_SPACE) || !o_disp_on;
        end
    end

    // Helper: length of each busy run and the length expected for it
    logic acc;
    logic [`CHLCD_CNT_W-1:0] run_q, exp_q;
    assign acc = i_wr_stb && !o_busy;
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            run_q <= '0;
            exp_q <= '0;
        end else begin
            run_q <= o_busy ? run_q + `CHLCD_CNT_ONE : '0;
            // Expected length from the command code, independent of the engine
            if (acc) begin
                exp_q <= (!i_rs_data && i_wdata[7:2] == 6'h00 && i_wdata[1:0] != 2'h0) ?
                    LONG_CNT : SHORT_CNT;
            end
        end
    end

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    a_busy_set: assert property (acc |=> o_busy)
        else $error("busy not raised after accepted write");
    a_busy_length: assert property ($fell(o_busy) |-> run_q == exp_q)
        else $error("busy run length differs from execution time");
    a_status_read: assert property (i_rd_stb && !cg_mode_q |=>
        o_rvalid && o_rdata == {$past(o_busy), $past(o_cursor_addr)})
        else $error("status byte wrong");
    a_busy_drop: assert property (o_busy && i_wr_stb |=>
        o_wr_drop && $stable(o_cursor_addr) && $stable(o_disp_on))
        else $error("write while busy changed state");
    a_home_clear: assert property (acc && !i_rs_data && i_wdata inside {8'h01, 8'h02}
        |=> o_cursor_addr == 7'h00 && o_disp_offset == 7'h00 ##1 o_busy[*8])
        else $error("home or clear misbehaved");
    a_entry_set: assert property (acc && !i_rs_data && i_wdata[7:2] == 6'h01 |=>
        o_entry_inc == $past(i_wdata[1]) && o_entry_shift == $past(i_wdata[0]))
        else $error("entry mode not set");
    a_disp_ctrl: assert property (acc && !i_rs_data && i_wdata[7:3] == 5'h01 |=>
        {o_disp_on, o_cursor_on, o_blink_on} == $past(i_wdata[2:0]))
        else $error("display control not set");
    a_cursor_right: assert property (acc && !i_rs_data && i_wdata == 8'h14 |=>
        o_cursor_addr == $past(o_cursor_addr) + 7'h01)
        else $error("cursor right shift wrong");
    a_func_set: assert property (acc && !i_rs_data && i_wdata == 8'h3C |=> o_two_line)
        else $error("function default not taken");
    a_cg_load: assert property (acc && !i_rs_data && i_wdata[7:6] == 2'h1 |=>
        o_cg_addr == $past(i_wdata[5:0]))
        else $error("generator address not loaded");
    a_dd_load: assert property (acc && !i_rs_data && i_wdata[7] |=>
        o_cursor_addr == $past(i_wdata[6:0]))
        else $error("display address not loaded");
    a_blank_off: assert property (!o_disp_on |=> o_scan_blank)
        else $error("dark display shows glyphs");
    a_data_step: assert property (acc && i_rs_data && !cg_mode_q && o_entry_inc |=>
        o_cursor_addr == $past(o_cursor_addr) + 7'h01)
        else $error("data write did not step address");

    c_clear: cover property (acc && !i_rs_data && i_wdata == 8'h01 ##1 o_busy[*8]);
    c_poll_busy: cover property (i_rd_stb && o_busy ##1 o_rvalid);
    c_data_write: cover property (acc && i_rs_data && !cg_mode_q);
    c_cg_write: cover property (acc && i_rs_data && cg_mode_q);
endmodule : chlcd_decoder

// ### chlcd_regs.svh
// Constants of the character display command decoder: timings, codes, reset values.
// Assumes a 50 MHz system clock; included by bare name wherever needed.
`ifndef CHLCD_REGS_SVH
`define CHLCD_REGS_SVH

// Timing
`define CHLCD_CLK_NS 20
`define CHLCD_T_LONG_NS 1650000
`define CHLCD_T_SHORT_NS 40000
`define CHLCD_LONG_CYC (`CHLCD_T_LONG_NS / `CHLCD_CLK_NS)
`define CHLCD_SHORT_CYC (`CHLCD_T_SHORT_NS / `CHLCD_CLK_NS)
`define CHLCD_CNT_W 17
`define CHLCD_CNT_ONE 17'h0_0001

// Status layout and codes
`define CHLCD_BUSY_BIT 7
`define CHLCD_CHAR_SPACE 8'h20
`define CHLCD_CG_PAGE 2'h2
`define CHLCD_LAST_CELL 7'h7F

// Reset values
`define CHLCD_RST_DISP_ON 1'b0
`define CHLCD_RST_CURSOR_ON 1'b0
`define CHLCD_RST_BLINK_ON 1'b0
`define CHLCD_RST_ENTRY_INC 1'b1
`define CHLCD_RST_ENTRY_SHIFT 1'b0
`define CHLCD_RST_TWO_LINE 1'b1

`endif

// ### chlcd_pkg.sv
// Types of the character display command decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package chlcd_pkg;

    typedef enum logic [1:0] {
        CHLCD_ST_IDLE  = 2'b00,
        CHLCD_ST_BUSY  = 2'b01,
        CHLCD_ST_CLEAR = 2'b10
    } chlcd_state_e;

    typedef enum logic [3:0] {
        CHLCD_C_NOP    = 4'b0000,
        CHLCD_C_CLEAR  = 4'b0001,
        CHLCD_C_HOME   = 4'b0010,
        CHLCD_C_ENTRY  = 4'b0011,
        CHLCD_C_DISP   = 4'b0100,
        CHLCD_C_SHIFT  = 4'b0101,
        CHLCD_C_FUNC   = 4'b0110,
        CHLCD_C_CGADDR = 4'b0111,
        CHLCD_C_DDADDR = 4'b1000
    } chlcd_cmd_e;

    // Highest set bit picks the command group
    function automatic chlcd_cmd_e chlcd_classify(input logic [7:0] c);
        if (c[7]) return CHLCD_C_DDADDR;
        else if (c[6]) return CHLCD_C_CGADDR;
        else if (c[5]) return CHLCD_C_FUNC;
        else if (c[4]) return CHLCD_C_SHIFT;
        else if (c[3]) return CHLCD_C_DISP;
        else if (c[2]) return CHLCD_C_ENTRY;
        else if (c[1]) return CHLCD_C_HOME;
        else if (c[0]) return CHLCD_C_CLEAR;
        else return CHLCD_C_NOP;
    endfunction : chlcd_classify

endpackage : chlcd_pkg

// ### chlcd_mem.sv
// Character store: 128 display cells at 0x00-0x7F, 64 generator bytes at 0x80-0xBF.
// Assumes one writer and one reader on the same clock; read data is registered.
`timescale 1ns/1ns
module chlcd_mem (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // Write port
    input wire logic i_we,
    input wire logic [7:0] i_waddr,
    input wire logic [7:0] i_wdata,
    // Read port
    input wire logic [7:0] i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem_q [0:255];
    logic [7:0] rdata_d;

    // Array read, registered below
    always_comb begin
        rdata_d = mem_q[i_raddr];
    end

    // No reset on the array; contents undefined until cleared
    always_ff @(posedge i_sys_clk) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= rdata_d;
        end
    end
endmodule : chlcd_mem

// ### chlcd_host.sv
// Host-side model: issues command and character writes and status reads.
// Assumes the decoder shares i_sys_clk and samples requests at its rising edge.
`timescale 1ns/1ns
module chlcd_host (
    // Clock
    input wire logic i_sys_clk,
    // Requests toward the decoder
    output logic o_wr_stb,
    output logic o_rs_data,
    output logic [7:0] o_wdata,
    output logic o_rd_stb,
    // Status answer
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid
);
    // Idle lines at time zero
    initial begin
        o_wr_stb = 1'b0;
        o_rs_data = 1'b0;
        o_wdata = 8'h00;
        o_rd_stb = 1'b0;
    end

    // One-cycle write strobe; released lines scrambled so stale data never looks valid
    task automatic wr(input logic rs, input logic [7:0] d);
        @(posedge i_sys_clk);
        o_wr_stb <= 1'b1;
        o_rs_data <= rs;
        o_wdata <= d;
        @(posedge i_sys_clk);
        o_wr_stb <= 1'b0;
        o_rs_data <= ~rs;
        o_wdata <= ~d;
        #1;
    endtask : wr

    // Status read, answer taken one cycle after the request edge
    task automatic rd(output logic [7:0] v, output logic ok);
        @(posedge i_sys_clk);
        o_rd_stb <= 1'b1;
        @(posedge i_sys_clk);
        o_rd_stb <= 1'b0;
        #1;
        v = i_rdata;
        ok = (i_rvalid === 1'b1);
    endtask : rd

    // Poll busy before any new write; bounded so a stuck flag cannot hang us
    task automatic wait_ready(output logic [7:0] v, output logic ok);
        logic vok;
        ok = 1'b0;
        for (int i = 0; i < 1500 && !ok; i++) begin
            rd(v, vok);
            ok = vok && (v[7] === 1'b0);
        end
    endtask : wait_ready
endmodule : chlcd_host

// ### test_char_lcd_command_decoder.sv
// Self-checking bench of the display command decoder against an integer model.
// Assumes chlcd_decoder, chlcd_mem and chlcd_host are compiled beforehand.
`timescale 1ns/1ns
module test_char_lcd_command_decoder;
    import chlcd_pkg::*;

    localparam int LONG = 200;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_stb, rs_data, rd_stb, rvalid, busy, wr_drop, scan_blank;
    logic disp_on, cursor_on, blink_on, entry_inc, entry_shift, two_line;
    logic [7:0] wdata, rdata, scan_code;
    logic [6:0] cursor_addr, disp_offset;
    logic [6:0] scan_addr = 7'h00;
    logic [5:0] cg_addr;
    int n_mismatch = 0;
    int n_compared = 0;
    int seed = 55;
    int mem[128];
    int m_cur = 0, m_off = 0, m_cga = 0, m_cg = 0, m_inc = 1, m_sh = 0;
    int m_disp = 0, m_crs = 0, m_blk = 0, m_two = 1;

    always #10 sys_clk = ~sys_clk;

    chlcd_decoder #(.P_LONG_CYC(LONG)) dut (
        .i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_wr_stb(wr_stb), .i_rs_data(rs_data),
        .i_wdata(wdata), .i_rd_stb(rd_stb), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_busy(busy), .o_wr_drop(wr_drop), .o_disp_on(disp_on), .o_cursor_on(cursor_on),
        .o_blink_on(blink_on), .o_entry_inc(entry_inc), .o_entry_shift(entry_shift),
        .o_two_line(two_line), .o_cursor_addr(cursor_addr), .o_disp_offset(disp_offset),
        .o_cg_addr(cg_addr), .i_scan_addr(scan_addr), .o_scan_code(scan_code),
        .o_scan_blank(scan_blank)
    );

    chlcd_host host (
        .i_sys_clk(sys_clk), .o_wr_stb(wr_stb), .o_rs_data(rs_data), .o_wdata(wdata),
        .o_rd_stb(rd_stb), .i_rdata(rdata), .i_rvalid(rvalid)
    );

    // Verdict and end of run, shared by the main sequence and the watchdog
    task automatic stop_test();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk

    // Address the status byte should show: generator address in that mode
    function automatic logic [6:0] exp_addr();
        return m_cg != 0 ? 7'(m_cga) : 7'(m_cur);
    endfunction : exp_addr

    // Integer model of one accepted byte; highest set bit picks the group
    task automatic model(input logic rs, input logic [7:0] d);
        int st;
        st = m_inc != 0 ? 1 : -1;
        if (rs) begin
            if (m_cg != 0) m_cga = (m_cga + st) & 63;
            else begin
                mem[m_cur] = d;
                m_cur = (m_cur + st) & 127;
                if (m_sh != 0) m_off = (m_off + st) & 127;
            end
        end else if (d[7]) begin
            m_cur = d[6:0];
            m_cg = 0;
        end else if (d[6]) begin
            m_cga = d[5:0];
            m_cg = 1;
        end else if (d[5]) m_two = d[3];
        else if (d[4]) begin
            if (d[3]) m_off = (m_off + (d[2] ? -1 : 1)) & 127;
            else m_cur = (m_cur + (d[2] ? 1 : -1)) & 127;
        end else if (d[3]) begin
            m_disp = d[2];
            m_crs = d[1];
            m_blk = d[0];
        end else if (d[2]) begin
            m_inc = d[1];
            m_sh = d[0];
        end else if (d[1] || d[0]) begin
            m_cur = 0;
            m_off = 0;
            m_cg = 0;
            if (d == 8'h01) begin
                m_inc = 1;
                foreach (mem[i]) mem[i] = 32;
            end
        end
    endtask : model

    // Full write: poll ready, write, read status while busy, time the busy span
    task automatic cmd(input logic rs, input logic [7:0] d);
        logic [7:0] v;
        logic ok;
        int n;
        host.wait_ready(v, ok);
        chk(ok && v === {1'b0, exp_addr()}, "idle status");
        host.wr(rs, d);
        model(rs, d);
        host.rd(v, ok);
        chk(ok && v === {1'b1, exp_addr()}, "busy status");
        n = 2;
        while (busy === 1'b1 && n < 5000) begin
            n++;
            @(posedge sys_clk);
            #1;
        end
        chk(n == ((!rs && (d == 8'h01 || d == 8'h02)) ? LONG : 2000), "busy span");
        chk(cursor_addr === 7'(m_cur) && disp_offset === 7'(m_off), "cursor");
        chk(cg_addr === 6'(m_cga), "generator address");
        chk({disp_on, cursor_on, blink_on} === {m_disp[0], m_crs[0], m_blk[0]}, "display");
        chk({entry_inc, entry_shift, two_line} === {m_inc[0], m_sh[0], m_two[0]}, "mode");
    endtask : cmd

    // Random printable codes written from the current cursor
    task automatic chars(input int n);
        for (int i = 0; i < n; i++) cmd(1'b1, 8'h20 + 8'($random(seed) & 63));
    endtask : chars

    // Every visible cell, two cycles after its address is presented
    task automatic scan_all();
        logic [7:0] c;
        for (int a = 0; a < 128; a++) begin
            @(posedge sys_clk);
            scan_addr <= 7'(a);
            @(posedge sys_clk);
            @(posedge sys_clk);
            #1;
            c = 8'(mem[(a + m_off) & 127]);
            chk(scan_code === c && scan_blank === (c == 8'h20 || m_disp == 0), "scan");
        end
    endtask : scan_all

    // Watchdog sized for about forty 2000-cycle commands plus scans
    initial begin
        repeat (90000) @(posedge sys_clk);
        n_mismatch++;
        stop_test();
    end

    // Main sequence
    initial begin
        logic [7:0] v;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({busy, disp_on, entry_inc, two_line, scan_blank, cursor_addr} === 12'h380, "reset");
        cmd(1'b0, 8'h01);
        cmd(1'b0, 8'h30);
        cmd(1'b0, 8'h3C);
        for (int i = 0; i < 8; i++) cmd(1'b0, 8'h08 | 8'(i));
        for (int i = 0; i < 4; i++) cmd(1'b0, 8'h10 | 8'(i << 2));
        cmd(1'b0, 8'h02);
        for (int i = 0; i < 4; i++) cmd(1'b0, 8'h04 | 8'(i));
        cmd(1'b0, 8'h06);
        cmd(1'b0, 8'hFE);
        chars(3);
        cmd(1'b0, 8'h04);
        chars(3);
        cmd(1'b0, 8'h80 | 8'($random(seed) & 127));
        cmd(1'b0, 8'h07);
        chars(3);
        cmd(1'b0, 8'h40 | 8'($random(seed) & 63));
        cmd(1'b1, 8'h55);
        // Second write lands while busy: must be dropped without effect
        host.wait_ready(v, v[0]);
        host.wr(1'b0, 8'h85);
        model(1'b0, 8'h85);
        host.wr(1'b0, 8'h8A);
        chk(wr_drop === 1'b1 && cursor_addr === 7'h05, "dropped write");
        cmd(1'b1, 8'h39);
        scan_all();
        stop_test();
    end
endmodule : test_char_lcd_command_decoder
